/* design/bit_test_skip_pkg.sv */
// Functional notes
// - Opcode 1011: skip next when bit clear
// - Clear bit: discard next, run no-op
// - Opcode 1010: skip next when bit set
// - Bank bit zero: use access bank
// - Bank bit one: bank register plus address
// - One cycle; two if skip; three if long
// - Discarded cycles change no state or flags
package bit_test_skip_pkg;

    localparam logic [3:0] OPC_SKIP_CLEAR = 4'hb;
    localparam logic [3:0] OPC_SKIP_SET = 4'ha;
    localparam int OPC_MSB = 15;
    localparam int OPC_LSB = 12;
    localparam int BIT_MSB = 11;
    localparam int BIT_LSB = 9;
    localparam int BANK_SEL_POS = 8;
    localparam int ADDR_MSB = 7;
    localparam int ADDR_LSB = 0;
    // Access bank: low half maps to bank 0, high half to bank 0xf
    localparam logic [7:0] ACCESS_SPLIT = 8'h80;
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
    localparam logic [1:0] PHASE_RESET = 2'h0;
    localparam logic [1:0] NOP_COUNT_RESET = 2'h0;
    localparam logic [1:0] NOP_ONE_WORD = 2'h1;
    localparam logic [1:0] NOP_TWO_WORD = 2'h2;

    typedef enum logic [1:0] {
        PH_Q1 = 2'b00,
        PH_Q2 = 2'b01,
        PH_Q3 = 2'b10,
        PH_Q4 = 2'b11
    } phase_t;

    typedef struct packed {
        logic [15:0] word;
        logic second_word;
        logic valid;
    } instr_t;

    typedef struct packed {
        logic [11:0] addr;
        logic rd;
    } file_req_t;

endpackage

/* design/skip_phase_counter.sv */
`timescale 1ns/1ps
module skip_phase_counter
    import bit_test_skip_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    output phase_t phase_o,
    output logic last_o
);
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            phase_o <= PH_Q1;
        end else begin
            phase_o <= phase_t'(phase_o + 2'h1);
        end
    end

    assign last_o = (phase_o == PH_Q4);
endmodule

/* design/bit_test_skip_execution.sv */
`timescale 1ns/1ps
module bit_test_skip_execution
    import bit_test_skip_pkg::*;
(
    // Clock and reset
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    // Instruction latched at the start of the cycle
    input instr_t INSTR_I,
    input wire logic [3:0] BANK_SELECT_REGISTER_I,
    // File register read data, valid in Q3
    input wire logic [7:0] FILE_DATA_I,
    // File register read port
    output file_req_t FILE_REQ_O,
    // Cycle and result reporting
    output phase_t PHASE_O,
    output logic CYCLE_END_O,
    output logic IS_BIT_TEST_O,
    output logic SKIP_O,
    output logic NOP_CYCLE_O,
    output logic RETIRE_O
);
    ////////////////////////////////////////////////////////////////////
    // Quarter-phase sequencer
    phase_t phase;
    logic last_q;
    logic at_q1;
    logic at_q3;

    skip_phase_counter u_phase (
        .clk_i(CLK_SYS_I),
        .rst_i(RST_I),
        .phase_o(phase),
        .last_o(last_q)
    );

    assign at_q1 = (phase == PH_Q1);
    assign at_q3 = (phase == PH_Q3);

    ////////////////////////////////////////////////////////////////////
    // Operand fields of the presented word
    logic [3:0] opc;
    logic [2:0] bit_sel;
    logic bank_sel;
    logic [7:0] file_addr;
    logic is_clear;
    logic is_set;
    logic in_nop;
    logic decode_hit;
    logic [11:0] nxt_addr;

    assign opc = INSTR_I.word[OPC_MSB:OPC_LSB];
    assign bit_sel = INSTR_I.word[BIT_MSB:BIT_LSB];
    assign bank_sel = INSTR_I.word[BANK_SEL_POS];
    assign file_addr = INSTR_I.word[ADDR_MSB:ADDR_LSB];
    assign is_clear = (opc == OPC_SKIP_CLEAR);
    assign is_set = (opc == OPC_SKIP_SET);

    // A word fetched into a no-op slot is never decoded
    assign decode_hit = INSTR_I.valid && !in_nop
                        && (is_clear || is_set);

    // Access bank splits at the midpoint; with the bank bit set the bank register supplies the upper bits
    always_comb begin
        if (bank_sel) begin
            nxt_addr = {BANK_SELECT_REGISTER_I, file_addr};
        end else if (file_addr < ACCESS_SPLIT) begin
            nxt_addr = {ACCESS_LOW_BANK, file_addr};
        end else begin
            nxt_addr = {ACCESS_HIGH_BANK, file_addr};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Q1: capture the decoded bit test
    logic bit_test_ff;
    logic nxt_bit_test;
    logic want_set_ff;
    logic nxt_want_set;
    logic [2:0] bit_idx_ff;
    logic [2:0] nxt_bit_idx;

    always_comb begin
        nxt_bit_test = bit_test_ff;
        nxt_want_set = want_set_ff;
        nxt_bit_idx = bit_idx_ff;
        if (at_q1) begin
            nxt_bit_test = decode_hit;
            nxt_want_set = is_set;
            nxt_bit_idx = bit_sel;
        end
    end

    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            bit_test_ff <= 1'b0;
        end else begin
            bit_test_ff <= nxt_bit_test;
        end
    end

    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            want_set_ff <= 1'b0;
            bit_idx_ff <= 3'h0;
        end else begin
            want_set_ff <= nxt_want_set;
            bit_idx_ff <= nxt_bit_idx;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Q2: read request towards the file register port
    file_req_t nxt_req;

    always_comb begin
        nxt_req.rd = at_q1 && decode_hit;
        nxt_req.addr = at_q1 ? nxt_addr : FILE_REQ_O.addr;
    end

    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            FILE_REQ_O <= '0;
        end else begin
            FILE_REQ_O <= nxt_req;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Q3: sample the selected bit while the read data stand
    logic bit_val_ff;
    logic nxt_bit_val;

    always_comb begin
        nxt_bit_val = bit_val_ff;
        if (at_q3) begin
            nxt_bit_val = FILE_DATA_I[bit_idx_ff];
        end
    end

    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            bit_val_ff <= 1'b0;
        end else begin
            bit_val_ff <= nxt_bit_val;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Q4: skip decision and the count of discarded words
    logic skip_now;
    logic [1:0] nop_cnt_ff;
    logic [1:0] nxt_nop_cnt;

    // Clear test skips on zero, set test on one
    assign skip_now = bit_test_ff && (bit_val_ff == want_set_ff);
    assign in_nop = (nop_cnt_ff != NOP_COUNT_RESET);

    // Length of the following word is only known at Q4, so the
    // count is loaded there rather than at decode
    always_comb begin
        nxt_nop_cnt = nop_cnt_ff;
        if (last_q) begin
            if (skip_now) begin
                if (INSTR_I.second_word) begin
                    nxt_nop_cnt = NOP_TWO_WORD;
                end else begin
                    nxt_nop_cnt = NOP_ONE_WORD;
                end
            end else if (in_nop) begin
                nxt_nop_cnt = nop_cnt_ff - 2'h1;
            end
        end
    end

    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            nop_cnt_ff <= NOP_COUNT_RESET;
        end else begin
            nop_cnt_ff <= nxt_nop_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Status outputs; Q4 writes nothing back and no flag is touched
    logic nxt_skip;
    logic nxt_nop_cycle;
    logic nxt_retire;

    assign nxt_skip = last_q && skip_now;
    assign nxt_nop_cycle = in_nop;
    // Discarded words never retire, so they alter nothing
    assign nxt_retire = last_q && !in_nop;

    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            PHASE_O <= PH_Q1;
            CYCLE_END_O <= 1'b0;
        end else begin
            PHASE_O <= phase;
            CYCLE_END_O <= last_q;
        end
    end

    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            IS_BIT_TEST_O <= 1'b0;
            SKIP_O <= 1'b0;
        end else begin
            IS_BIT_TEST_O <= bit_test_ff;
            SKIP_O <= nxt_skip;
        end
    end

    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            NOP_CYCLE_O <= 1'b0;
            RETIRE_O <= 1'b0;
        end else begin
            NOP_CYCLE_O <= nxt_nop_cycle;
            RETIRE_O <= nxt_retire;
        end
    end
endmodule

/* verif/bit_test_skip_chk.sv */
`timescale 1ns/1ps
module bit_test_skip_chk
    import bit_test_skip_pkg::*;
(
    // Clock, reset, inputs
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    input instr_t INSTR_I,
    input wire logic [3:0] BANK_SELECT_REGISTER_I,
    input wire logic [7:0] FILE_DATA_I,
    // Outputs
    input file_req_t FILE_REQ_O,
    input wire logic IS_BIT_TEST_O,
    input wire logic SKIP_O,
    input wire logic NOP_CYCLE_O,
    input wire logic RETIRE_O
);
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (RST_I);
    logic hit;
    logic [3:0] bnk;
    logic rd;
    // Skip wanted: set test on one, clear test on zero
    assign hit = FILE_DATA_I[INSTR_I.word[11:9]]
        ^ (INSTR_I.word[15:12] == OPC_SKIP_CLEAR);
    assign bnk = INSTR_I.word[7] ? ACCESS_HIGH_BANK : ACCESS_LOW_BANK;
    assign rd = FILE_REQ_O.rd;
    sequence nop_word;
        NOP_CYCLE_O [*4];
    endsequence
    chk_skip_taken: assert property (
        rd && hit |-> ##3 SKIP_O) else $error("skip missing");
    chk_no_skip: assert property (
        rd && !hit |-> ##3 !SKIP_O) else $error("bad skip");
    chk_access_bank: assert property (
        rd && !INSTR_I.word[8] |-> FILE_REQ_O.addr == {bnk, INSTR_I.word[7:0]}
    ) else $error("access addr");
    chk_bank_reg: assert property (
        rd && INSTR_I.word[8] |-> FILE_REQ_O.addr[11:8] ==
        BANK_SELECT_REGISTER_I) else $error("bank addr");
    chk_read_phase: assert property (
        rd |-> ##1 (IS_BIT_TEST_O && !rd)) else $error("read phase");
    chk_skip_retire: assert property (
        SKIP_O |-> RETIRE_O && $past(rd, 3)) else $error("skip timing");
    chk_nop_short: assert property (
        SKIP_O && !$past(INSTR_I.second_word, 2) |->
        ##[0:1] nop_word ##1 !NOP_CYCLE_O) else $error("nop length");
    chk_nop_long: assert property (
        SKIP_O && $past(INSTR_I.second_word, 2) |->
        ##[0:1] nop_word ##1 nop_word) else $error("long nop");
    chk_nop_quiet: assert property (
        NOP_CYCLE_O && !$rose(NOP_CYCLE_O) |-> !RETIRE_O)
        else $error("nop retired");
endmodule
bind bit_test_skip_execution bit_test_skip_chk i_chk (
    .CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I), .INSTR_I(INSTR_I),
    .BANK_SELECT_REGISTER_I(BANK_SELECT_REGISTER_I),
    .FILE_DATA_I(FILE_DATA_I), .FILE_REQ_O(FILE_REQ_O),
    .IS_BIT_TEST_O(IS_BIT_TEST_O), .SKIP_O(SKIP_O),
    .NOP_CYCLE_O(NOP_CYCLE_O), .RETIRE_O(RETIRE_O)
);

/* verif/bit_test_skip_execution_test.sv */
`timescale 1ns/1ps
module bit_test_skip_execution_test;
    import bit_test_skip_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    instr_t instr = '0;
    logic [3:0] bank = 4'h0;
    logic [7:0] data = 8'h00;
    file_req_t req;
    logic skip, nop, retire, isbt;
    logic cyc_end;
    phase_t phase;
    int n_fail = 0;
    int n_compared = 0;
    bit_test_skip_execution i_dut (
        .CLK_SYS_I(clk), .RST_I(rst), .INSTR_I(instr),
        .BANK_SELECT_REGISTER_I(bank), .FILE_DATA_I(data),
        .FILE_REQ_O(req), .PHASE_O(phase), .CYCLE_END_O(cyc_end),
        .IS_BIT_TEST_O(isbt), .SKIP_O(skip), .NOP_CYCLE_O(nop),
        .RETIRE_O(retire)
    );
    task automatic cmp(input string n, input logic [11:0] e,
        input logic [11:0] g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic stop_test;
        if (n_fail == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // One instruction then a filler; filler is discarded on a skip
    task automatic bt(input logic [15:0] w, input logic [3:0] b,
        input logic [7:0] d, input logic sw, input logic es,
        input logic er, input logic [11:0] ea);
        instr <= '{w, sw, 1'b1};
        bank <= b;
        data <= d;
        @(posedge clk);
        #1 cmp("rd", {11'h0, er}, {11'h0, req.rd});
        cmp("addr", er ? ea : 12'h0, er ? req.addr : 12'h0);
        repeat (3) @(posedge clk);
        instr <= '{16'h0000, 1'b0, 1'b1};
        #1 cmp("skip", {11'h0, es}, {11'h0, skip});
        cmp("end", 12'h1, {11'h0, cyc_end});
        cmp("phase", {10'h0, PH_Q4}, {10'h0, phase});
        cmp("isbt", {11'h0, er}, {11'h0, isbt});
        cmp("retire", 12'h1, {11'h0, retire});
        repeat (2) @(posedge clk);
        #1 cmp("nop", {11'h0, es}, {11'h0, nop});
        repeat (2) @(posedge clk);
        #1 cmp("retire", {11'h0, !es}, {11'h0, retire});
        if (es && sw) begin
            repeat (2) @(posedge clk);
            #1 cmp("nop2", 12'h1, {11'h0, nop});
            repeat (2) @(posedge clk);
            #1 cmp("retire2", 12'h0, {11'h0, retire});
        end
        // Spare filler cycle brings the next call back onto an edge
        repeat (4) @(posedge clk);
    endtask
    initial begin
        forever #2 clk = ~clk;
    end
    initial begin
        #1000 n_fail++;
        stop_test;
    end
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        bt(16'hb612, 4'h5, 8'hf7, 1'b0, 1'b1, 1'b1, 12'h012);
        bt(16'hb734, 4'h5, 8'h08, 1'b0, 1'b0, 1'b1, 12'h534);
        bt(16'hae90, 4'h5, 8'h80, 1'b1, 1'b1, 1'b1, 12'hf90);
        bt(16'ha101, 4'ha, 8'hfe, 1'b0, 1'b0, 1'b1, 12'ha01);
        bt(16'h9612, 4'h0, 8'h00, 1'b0, 1'b0, 1'b0, 12'h000);
        stop_test;
    end
endmodule
